// ---- hdl/thr_hit_readout.v ----
// Per-chip hit readout: latency buffers, width digitizing, sparse output
`include "thr_map.vh"
`default_nettype none
// Operation
// - Comparator high while pulse exceeds threshold
// - Store comparator into buffer at write pointer
// - Buffer depth covers latency plus jitters
// - Free 16-bit counter latched on trigger
// - Shared jitter window and width counters
// - Read pointer loads earliest possible event slot
// - Read pointer runs faster than write
// - No trigger accepted while reading
// - Zero-to-one transition sets hit flag
// - Width counter counts consecutive ones
// - Hit time stamp latched on hit
// - Width value is four bits
// - Hit record: time, width, flag
// - Per-channel back-end record buffers
// - Add channel number, move to sparse buffer
// - Send 16-bit records on transmit command
// - External clock divided into internal rates
// - 128 identical channels
module thr_hit_readout (
    input  wire                core_clk,
    input  wire                srst,
    input  wire [`THR_NCH-1:0] compIn,
    input  wire                trigIn,
    input  wire                xmitCmd,
    output reg                 trigBusy,
    output reg  [`THR_TSW-1:0] eventStamp,
    output reg  [`THR_RECW-1:0] recData,
    output reg                 recValid,
    output reg                 recLast
);
    localparam ST_IDLE = 4'b0001;
    localparam ST_SCAN = 4'b0010;
    localparam ST_SEND = 4'b0100;
    localparam ST_DONE = 4'b1000;
    localparam SCANLEN = `THR_JIT_CYC * 2 + 16;
    // Read start sits latency plus jitter behind the write pointer
    localparam [31:0] BACKOFF = `THR_LAT_CYC + `THR_JIT_CYC;

    // Pin inputs pass two flops before any logic reads them
    reg [`THR_NCH-1:0] compMeta;
    reg [`THR_NCH-1:0] compSync;
    reg [2:0]          trigSy;
    reg [1:0]          xmitSy;
    wire               wrTick;
    wire               rdTick;
    reg [3:0]          state;
    reg [`THR_BUFW-1:0] wrPtr;
    reg [`THR_BUFW-1:0] rdPtr;
    reg [`THR_TSW-1:0] stampCnt;
    reg [`THR_HTW-1:0] scanIdx;
    reg [`THR_HTW:0]   jitCnt;
    reg [`THR_WW-1:0]  fsCnt;
    reg [`THR_NCH-1:0] prevBit;
    reg [`THR_NCH-1:0] busyCh;
    reg [`THR_NCH-1:0] hitFlag;
    reg [`THR_WW-1:0]  width   [0:`THR_NCH-1];
    reg [`THR_HTW-1:0] hitTime [0:`THR_NCH-1];
    reg [`THR_CHW-1:0] scanCh;
    reg                pushVal;
    reg [`THR_RECW-1:0] pushDat;
    wire               pushRdy;
    wire [`THR_RECW-1:0] popDat;
    wire               popVal;
    reg                sending;
    wire               trigRise;
    wire [`THR_NCH-1:0] rdBits;
    wire               scanEnd;

    assign trigRise = trigSy[1] & ~trigSy[2];
    assign scanEnd  = (scanIdx == SCANLEN[`THR_HTW-1:0]);

    thr_rate_div #(.DIV(`THR_WDIV)) uWr (
        .core_clk (core_clk),
        .srst     (srst),
        .tick     (wrTick)
    );
    thr_rate_div #(.DIV(`THR_RDIV)) uRd (
        .core_clk (core_clk),
        .srst     (srst),
        .tick     (rdTick)
    );

    always @(posedge core_clk) begin
        compMeta <= compIn;
        compSync <= compMeta;
        if (srst) begin
            trigSy <= 3'h0;
            xmitSy <= 2'h0;
        end else begin
            trigSy <= {trigSy[1:0], trigIn};
            xmitSy <= {xmitSy[0], xmitCmd};
        end
    end

    // Write pointer and stamp counter free-run on the write rate
    always @(posedge core_clk) begin
        if (srst) begin
            wrPtr    <= 8'h00;
            stampCnt <= 16'h0000;
        end else if (wrTick) begin
            wrPtr    <= wrPtr + 8'h01;
            stampCnt <= stampCnt + 16'h0001;
        end
    end

    // Per-channel circular buffers, one bit wide, depth covers latency
    genvar g;
    generate
        for (g = 0; g < `THR_NCH; g = g + 1) begin : gCh
            reg buffer [0:`THR_DEPTH-1];
            always @(posedge core_clk) begin
                if (wrTick) begin
                    buffer[wrPtr] <= compSync[g];
                end
            end
            assign rdBits[g] = buffer[rdPtr];
            always @(posedge core_clk) begin
                if (srst || (state == ST_IDLE && trigRise)) begin
                    prevBit[g]  <= 1'b0;
                    busyCh[g]   <= 1'b0;
                    hitFlag[g]  <= 1'b0;
                    width[g]    <= 4'h0;
                    hitTime[g]  <= 5'h00;
                end else if (state == ST_SCAN && rdTick && !scanEnd) begin
                    prevBit[g] <= rdBits[g];
                    if (!hitFlag[g] && !prevBit[g] && rdBits[g]) begin
                        hitFlag[g] <= 1'b1;
                        busyCh[g]  <= 1'b1;
                        width[g]   <= 4'h1;
                        hitTime[g] <= scanIdx;
                    end else if (busyCh[g] && rdBits[g]) begin
                        if (width[g] != `THR_WMAX) begin
                            width[g] <= width[g] + 4'h1;
                        end
                    end else begin
                        busyCh[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Sequencer: trigger, scan, then push sparse records
    always @(posedge core_clk) begin
        if (srst) begin
            state      <= ST_IDLE;
            rdPtr      <= 8'h00;
            scanIdx    <= 5'h00;
            jitCnt     <= 6'h00;
            fsCnt      <= 4'h0;
            eventStamp <= 16'h0000;
            trigBusy   <= 1'b0;
            scanCh     <= 7'h00;
            pushVal    <= 1'b0;
            pushDat    <= 16'h0000;
        end else begin
            case (state)
                ST_IDLE: begin
                    trigBusy <= 1'b0;
                    if (trigRise) begin
                        eventStamp <= stampCnt;
                        rdPtr <= wrPtr - BACKOFF[`THR_BUFW-1:0];
                        scanIdx  <= 5'h00;
                        jitCnt   <= 6'h00;
                        fsCnt    <= 4'h0;
                        trigBusy <= 1'b1;
                        state    <= ST_SCAN;
                    end
                end
                ST_SCAN: begin
                    if (rdTick) begin
                        if (scanEnd) begin
                            scanCh <= 7'h00;
                            state  <= ST_SEND;
                        end else begin
                            rdPtr   <= rdPtr + 8'h01;
                            scanIdx <= scanIdx + 5'h01;
                            // Jitter window then full-scale width span
                            if (jitCnt != 6'h3F) begin
                                jitCnt <= jitCnt + 6'h01;
                            end
                            if (jitCnt > 2*`THR_JIT_CYC
                                && fsCnt != `THR_WMAX) begin
                                fsCnt <= fsCnt + 4'h1;
                            end
                        end
                    end
                end
                ST_SEND: begin
                    // Stalls on a full FIFO so no record is lost
                    if (!pushVal || pushRdy) begin
                        if (hitFlag[scanCh]) begin
                            pushVal <= 1'b1;
                            pushDat <= {scanCh, hitTime[scanCh],
                                        width[scanCh]};
                        end else begin
                            pushVal <= 1'b0;
                        end
                        if (scanCh == 7'h7F) begin
                            state <= ST_DONE;
                        end else begin
                            scanCh <= scanCh + 7'h01;
                        end
                    end
                end
                ST_DONE: begin
                    if (pushRdy || !pushVal) begin
                        pushVal  <= 1'b0;
                        trigBusy <= 1'b0;
                        state    <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    thr_fifo #(
        .WIDTH (`THR_RECW),
        .DEPTH (`THR_FIFOD),
        .AW    (2)
    ) uFifo (
        .core_clk (core_clk),
        .srst     (srst),
        .inData   (pushDat),
        .inValid  (pushVal),
        .inReady  (pushRdy),
        .outData  (popDat),
        .outValid (popVal),
        .outReady (sending && !recValid)
    );

    // Records leave only while a transmit command is held
    always @(posedge core_clk) begin
        if (srst) begin
            sending  <= 1'b0;
            recData  <= 16'h0000;
            recValid <= 1'b0;
            recLast  <= 1'b0;
        end else begin
            sending  <= xmitSy[1];
            recValid <= sending && popVal && !recValid;
            if (sending && popVal && !recValid) begin
                recData <= popDat;
            end
            recLast <= sending && popVal && !recValid
                       && state == ST_IDLE;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/thr_map.vh ----
// Constants for the per-chip hit readout back end
`ifndef THR_MAP_VH
`define THR_MAP_VH
`define THR_NCH          128
`define THR_CHW          7
`define THR_TSW          16
`define THR_HTW          5
`define THR_WW           4
`define THR_WMAX         4'hF
`define THR_BUFW         8
`define THR_DEPTH        256
// Trigger figures in ns; depth covers latency plus jitters
`define THR_LAT_NS       9500
`define THR_JIT_NS       500
`define THR_WCLK_NS      100
`define THR_LAT_CYC      (`THR_LAT_NS / `THR_WCLK_NS)
`define THR_JIT_CYC      (`THR_JIT_NS / `THR_WCLK_NS)
// Write-clock and read-clock divide ratios of core_clk
`define THR_WDIV         2
`define THR_RDIV         1
`define THR_FIFOD        4
`define THR_RECW         16
`endif

// ---- hdl/thr_fifo.v ----
// Small synchronous FIFO with valid and ready on both sides
`default_nettype none
module thr_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             core_clk,
    input  wire             srst,
    input  wire [WIDTH-1:0] inData,
    input  wire             inValid,
    output wire             inReady,
    output wire [WIDTH-1:0] outData,
    output wire             outValid,
    input  wire             outReady
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wrPtr;
    reg [AW-1:0]    rdPtr;
    reg [AW:0]      count;
    wire            doWr;
    wire            doRd;
    assign inReady  = (count != DEPTH[AW:0]);
    assign outValid = (count != {(AW+1){1'b0}});
    assign outData  = mem[rdPtr];
    assign doWr     = inValid & inReady;
    assign doRd     = outValid & outReady;
    always @(posedge core_clk) begin
        if (srst) begin
            wrPtr <= {AW{1'b0}};
            rdPtr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (doWr) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (doRd) begin
                rdPtr <= rdPtr + 1'b1;
            end
            if (doWr && !doRd) begin
                count <= count + 1'b1;
            end else if (doRd && !doWr) begin
                count <= count - 1'b1;
            end
        end
    end
    always @(posedge core_clk) begin
        if (doWr) begin
            mem[wrPtr] <= inData;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/thr_rate_div.v ----
// Divider that turns core_clk into one-cycle rate enables
`default_nettype none
module thr_rate_div #(
    parameter DIV = 2
) (
    input  wire core_clk,
    input  wire srst,
    output reg  tick
);
    reg [7:0] cnt;
    always @(posedge core_clk) begin
        if (srst) begin
            cnt  <= 8'h00;
            tick <= 1'b0;
        end else if (cnt == DIV[7:0] - 8'h01) begin
            cnt  <= 8'h00;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 8'h01;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- sim/thr_readout_sva.sv ----
// Port-level assertions for the per-chip hit readout
`default_nettype none
module thr_readout_sva (
    input wire logic         core_clk,
    input wire logic         srst,
    input wire logic [127:0] compIn,
    input wire logic         trigIn,
    input wire logic         xmitCmd,
    input wire logic         trigBusy,
    input wire logic [15:0]  eventStamp,
    input wire logic [15:0]  recData,
    input wire logic         recValid,
    input wire logic         recLast
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       seen;
    logic [6:0] lastCh;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // Order is judged within one event only
    always @(posedge core_clk) begin
        if (srst || $rose(trigBusy)) begin
            seen <= 1'b0;
        end else if (recValid) begin
            seen <= 1'b1;
            lastCh <= recData[15:9];
        end
    end
    a_busy_on_trig: assert property (
        $rose(trigIn) && !trigBusy |-> ##[2:3] trigBusy)
        else $error("trigger not accepted");
    a_stamp_hold: assert property (
        trigBusy && $past(trigBusy) |-> $stable(eventStamp))
        else $error("time stamp moved while busy");
    a_stamp_new: assert property (
        $rose(trigBusy) |-> eventStamp != $past(eventStamp))
        else $error("time stamp not latched");
    a_xmit_gate: assert property (
        recValid |-> $past(xmitCmd, 2) || $past(xmitCmd, 3)
            || $past(xmitCmd, 4))
        else $error("record sent without command");
    a_valid_pulse: assert property (recValid |=> !recValid)
        else $error("record valid too long");
    a_width_nonzero: assert property (
        recValid |-> recData[3:0] != 4'h0)
        else $error("record with empty width");
    a_chan_ascend: assert property (
        recValid && seen |-> recData[15:9] > lastCh)
        else $error("channels out of order");
    a_time_range: assert property (
        recValid |-> recData[8:4] < 5'h1A)
        else $error("hit time outside scan");
    a_last_idle: assert property (
        recLast |-> recValid && !trigBusy)
        else $error("last marker misplaced");
    c_trig: cover property ($rose(trigBusy));
    c_sat: cover property (recValid && recData[3:0] == 4'hF);
    c_refused: cover property ($rose(trigIn) && trigBusy);
endmodule
bind thr_hit_readout thr_readout_sva chk_u (
    .core_clk(core_clk), .srst(srst), .compIn(compIn), .trigIn(trigIn),
    .xmitCmd(xmitCmd), .trigBusy(trigBusy), .eventStamp(eventStamp),
    .recData(recData), .recValid(recValid), .recLast(recLast));
`default_nettype wire

// ---- sim/thr_daq_model.sv ----
// Acquisition-side model: issues triggers and the transmit command
`default_nettype none
module thr_daq_model (
    input  wire logic core_clk,
    input  wire logic srst,
    input  wire logic trigBusy,
    input  wire logic fireReq,
    input  wire logic forceFire,
    input  wire logic xmitEn,
    input  wire logic slow,
    output var  logic trigIn,
    output var  logic xmitCmd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] hold = 4'h0;
    logic [3:0] phase = 4'h0;
    // Trigger held several cycles so the synchroniser cannot miss it
    always @(negedge core_clk) begin
        phase <= phase + 4'h1;
        if (srst)
            hold <= 4'h0;
        else if (fireReq && (!trigBusy || forceFire))
            hold <= 4'h4;
        else if (hold != 4'h0)
            hold <= hold - 4'h1;
    end
    always @* trigIn = (hold != 4'h0);
    always @* xmitCmd = xmitEn && !(slow && phase[3]);
endmodule
`default_nettype wire

// ---- sim/test_thr_hit_readout.sv ----
// Self-checking bench for the per-chip hit readout
`default_nettype none
module test_thr_hit_readout;
    timeunit 1ns;
    timeprecision 1ps;
    logic         core_clk = 1'b0;
    logic         srst = 1'b1;
    logic [127:0] compIn = '0;
    logic         fireReq = 1'b0;
    logic         forceFire = 1'b0;
    logic         xmitEn = 1'b0;
    logic         slow = 1'b0;
    wire logic    trigIn;
    wire logic    xmitCmd;
    wire logic    trigBusy;
    wire logic [15:0] eventStamp;
    wire logic [15:0] recData;
    wire logic    recValid;
    wire logic    recLast;
    logic [16:0]  expQ[$];
    logic [16:0]  e;
    logic [15:0]  stampPrev;
    int           mismatches = 0;
    int           n_tests = 0;
    int           seed = 55;
    int           cyc = 0;
    int           firePrev = -1;
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) cyc++;
    thr_hit_readout dut_u (
        .core_clk(core_clk), .srst(srst), .compIn(compIn), .trigIn(trigIn),
        .xmitCmd(xmitCmd), .trigBusy(trigBusy), .eventStamp(eventStamp),
        .recData(recData), .recValid(recValid), .recLast(recLast));
    thr_daq_model daq_u (
        .core_clk(core_clk), .srst(srst), .trigBusy(trigBusy),
        .fireReq(fireReq), .forceFire(forceFire), .xmitEn(xmitEn),
        .slow(slow), .trigIn(trigIn), .xmitCmd(xmitCmd));
    task automatic chk(input bit ok, input string msg);
        n_tests++;
        if (!ok) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Records stand one cycle, so they are looked at mid-cycle;
    // scan slot j covers stimulus steps 2j and 2j+1, so hit time is k
    always @(negedge core_clk) begin
        if (!srst && recLast === 1'b1)
            chk(recValid === 1'b1 && trigBusy === 1'b0,
                "last marker");
        if (!srst && recValid === 1'b1) begin
            if (expQ.size() == 0) begin
                chk(1'b0, "unexpected record");
            end else begin
                e = expQ.pop_front();
                chk(recData[15:9] === e[15:9], "channel");
                chk(recData[3:0] === e[3:0], "width");
                chk(recData[8:4] === e[8:4], "hit time");
            end
        end
    end
    task automatic wait_idle;
        int i;
        for (i = 0; i < 4000; i++) begin
            @(negedge core_clk);
            if (trigBusy === 1'b0 && expQ.size() == 0)
                break;
        end
        if (i == 4000) begin
            chk(1'b0, "readout hang");
            tally_and_finish;
        end
    endtask
    task automatic run_event(input int n, input bit hold, input bit slw);
        int k[6];
        int w[6];
        int ch[6];
        if (cyc % 2 != 0)
            @(negedge core_clk);
        xmitEn <= !hold;
        slow <= slw;
        for (int i = 0; i < n; i++) begin
            ch[i] = (i == 0 && n == 6) ? 0 : i * 21 + ($random(seed) & 15);
            if (i == n - 1 && n == 6)
                ch[i] = 127;
            k[i] = (i == 0) ? 4 : 4 + ($random(seed) & 3);
            w[i] = (i == 0) ? 16 : (i == 1) ? 1
                 : 1 + $unsigned($random(seed)) % (21 - k[i]);
            expQ.push_back({i == 0, 7'(ch[i]), 5'(k[i]),
                            4'(w[i] > 15 ? 15 : w[i])});
        end
        for (int t = 0; t < 200; t++) begin
            for (int i = 0; i < n; i++)
                compIn[ch[i]] = (t >= 2 * k[i]) && (t < 2 * (k[i] + w[i]));
            fireReq <= (t == 199);
            @(negedge core_clk);
        end
        fireReq <= 1'b0;
        compIn = '0;
        if (firePrev >= 0)
            stampPrev = eventStamp;
        repeat (6) @(negedge core_clk);
        chk(trigBusy === 1'b1, "trigger refused");
        if (firePrev >= 0)
            chk(eventStamp - stampPrev === 16'((cyc - firePrev) / 2),
                "stamp step");
        firePrev = cyc;
        stampPrev = eventStamp;
        if (hold) begin
            repeat (150) @(negedge core_clk);
            chk(trigBusy === 1'b1, "no stall when buffer full");
            forceFire <= 1'b1;
            fireReq <= 1'b1;
            repeat (8) @(negedge core_clk);
            forceFire <= 1'b0;
            fireReq <= 1'b0;
            repeat (10) @(negedge core_clk);
            chk(eventStamp === stampPrev, "trigger taken while busy");
            xmitEn <= 1'b1;
            slow <= 1'b1;
        end
        wait_idle;
    endtask
    initial begin
        repeat (3) @(negedge core_clk);
        srst <= 1'b0;
        repeat (4) @(negedge core_clk);
        run_event(6, 1'b1, 1'b0);
        run_event(5, 1'b0, 1'b1);
        run_event(1, 1'b0, 1'b0);
        run_event(0, 1'b0, 1'b0);
        repeat (20) @(negedge core_clk);
        tally_and_finish;
    end
endmodule
`default_nettype wire
